// >>> hdl/fskm_map.vh
// constants for the fsk modem core: avalon register map, field positions, timing
// assumes a 100 MHz core clock; all counts derived from that rate
`ifndef FSKM_MAP_VH
`define FSKM_MAP_VH
`define FSKM_CLK_HZ        100000000
// register byte addresses
`define FSKM_REG_CTRL      4'h0
`define FSKM_REG_STATUS    4'h4
`define FSKM_REG_DAC       4'h8
// control field positions
`define FSKM_CTRL_RX_IDLE  0
`define FSKM_CTRL_KICK_EXT 1
`define FSKM_CTRL_CLK_MON  2
`define FSKM_CTRL_RESET    3'h5
// status field positions
`define FSKM_ST_CARRIER    0
`define FSKM_ST_RX_BIT     1
`define FSKM_ST_TX_MODE    2
`define FSKM_ST_FAULT      3
`define FSKM_ST_EXT_CLK    4
`define FSKM_ST_ALARM_HI   5
// tone and bit figures
`define FSKM_MARK_HZ       1200
`define FSKM_SPACE_HZ      2200
`define FSKM_BAUD          1200
`define FSKM_ACC_W         32
// increment = f * 2^32 / fclk
`define FSKM_MARK_INC      ((64'd1200 << 32) / 64'd100000000)
`define FSKM_SPACE_INC     ((64'd2200 << 32) / 64'd100000000)
// trapezoid: 8 bit output, idle 0.5 V = mid code, swing +-0.25 V
`define FSKM_OUT_MID       8'h80
`define FSKM_OUT_LO        8'h40
`define FSKM_OUT_HI        8'hc0
// slew per clock step: 1860 V/s and 3300 V/s, 0.5 V span = 128 codes
`define FSKM_SLEW_MARK_VS  1860
`define FSKM_SLEW_SPACE_VS 3300
`define FSKM_SLEW_MARK_DIV  ((`FSKM_CLK_HZ / 256) / `FSKM_SLEW_MARK_VS)
`define FSKM_SLEW_SPACE_DIV ((`FSKM_CLK_HZ / 256) / `FSKM_SLEW_SPACE_VS)
// demod: half-period threshold between 1200 Hz and 2200 Hz half periods
`define FSKM_HALF_MARK     (`FSKM_CLK_HZ / (2 * `FSKM_MARK_HZ))
`define FSKM_HALF_SPACE    (`FSKM_CLK_HZ / (2 * `FSKM_SPACE_HZ))
`define FSKM_HALF_THRESH   ((`FSKM_HALF_MARK + `FSKM_HALF_SPACE) / 2)
// carrier: 4 pulses, each within 2.5 ms
`define FSKM_CD_PULSES     4
`define FSKM_CD_GAP_US     2500
`define FSKM_CD_GAP_CYC    (`FSKM_CD_GAP_US * (`FSKM_CLK_HZ / 1000000))
// watchdog: internal kick 1.8 kHz, timeout 53 ms, reset pulse 140 us
`define FSKM_KICK_HZ       1800
`define FSKM_KICK_DIV      (`FSKM_CLK_HZ / `FSKM_KICK_HZ)
`define FSKM_WDT_MS        53
`define FSKM_WDT_CYC       (`FSKM_WDT_MS * (`FSKM_CLK_HZ / 1000))
`define FSKM_WDT_RST_US    140
`define FSKM_WDT_RST_CYC   (`FSKM_WDT_RST_US * (`FSKM_CLK_HZ / 1000000))
`define FSKM_DAC_W         17
`endif

// >>> hdl/fskm_modem.v
// digital core of a half-duplex fsk modem: modulator, demodulator, carrier
// detect, watchdog, sigma-delta dac and pin straps, registers on avalon-mm.
// assumes the comparator, strap and kick pins are asynchronous to core_clk_in.
`include "fskm_map.vh"
module fskm_modem #(
  parameter CD_GAP_CYC  = `FSKM_CD_GAP_CYC,
  parameter WDT_CYC     = `FSKM_WDT_CYC,
  parameter WDT_RST_CYC = `FSKM_WDT_RST_CYC,
  parameter KICK_DIV    = `FSKM_KICK_DIV
) (
  input  wire        core_clk_in,
  input  wire        reset_in,
  input  wire        logic_reset_n_in,
  input  wire [3:0]  avs_address_in,
  input  wire        avs_read_in,
  input  wire        avs_write_in,
  input  wire [31:0] avs_writedata_in,
  input  wire [3:0]  avs_byteenable_in,
  output reg  [31:0] avs_readdata_out,
  output reg         avs_waitrequest_out,
  input  wire        tx_bit_in,
  input  wire        send_request_n_in,
  output reg  [7:0]  tx_tone_out,
  input  wire        rx_tone_in,
  input  wire        carrier_level_in,
  output reg         rx_bit_out,
  output reg         carrier_present_out,
  input  wire        clk_src_strap_in,
  output reg         osc_enable_out,
  input  wire        alarm_sel_in,
  input  wire        kick_in,
  input  wire        clk_fail_in,
  output reg         wdt_reset_n_out,
  output reg         dac_out
);
  //////////////////////////////////////////////////////////////////////////////
  // pin synchronisers: three stages, change accepted when stages 2 and 3 agree
  reg [2:0] s_rtsn_q, s_txb_q, s_rx_q, s_cdl_q, s_kick_q, s_strap_q, s_alarm_q, s_cf_q;
  reg       rtsn_q, txb_q, rx_q, cdl_q, kick_q, strap_q, alarm_q, cf_q;
  // reset pin is asynchronous too: filtered like the others, so a one-clock
  // glitch on it cannot reset only part of the logic
  reg [2:0] s_rstn_q;
  reg       rstn_q;
  wire      rst = reset_in | ~rstn_q;
  always @(posedge core_clk_in)
  begin
    s_rtsn_q  <= {s_rtsn_q[1:0],  send_request_n_in};
    s_txb_q   <= {s_txb_q[1:0],   tx_bit_in};
    s_rx_q    <= {s_rx_q[1:0],    rx_tone_in};
    s_cdl_q   <= {s_cdl_q[1:0],   carrier_level_in};
    s_kick_q  <= {s_kick_q[1:0],  kick_in};
    s_strap_q <= {s_strap_q[1:0], clk_src_strap_in};
    s_alarm_q <= {s_alarm_q[1:0], alarm_sel_in};
    s_cf_q    <= {s_cf_q[1:0],    clk_fail_in};
    s_rstn_q  <= {s_rstn_q[1:0],  logic_reset_n_in};
    if (rst)
    begin
      rtsn_q <= 1'b1;
      txb_q  <= 1'b1;
      rx_q   <= 1'b0;
      cdl_q  <= 1'b0;
      kick_q <= 1'b0;
      cf_q   <= 1'b0;
    end
    else
    begin
      if (s_rtsn_q[2] == s_rtsn_q[1]) rtsn_q <= s_rtsn_q[2];
      if (s_txb_q[2] == s_txb_q[1])   txb_q  <= s_txb_q[2];
      if (s_rx_q[2] == s_rx_q[1])     rx_q   <= s_rx_q[2];
      if (s_cdl_q[2] == s_cdl_q[1])   cdl_q  <= s_cdl_q[2];
      if (s_kick_q[2] == s_kick_q[1]) kick_q <= s_kick_q[2];
      if (s_cf_q[2] == s_cf_q[1])     cf_q   <= s_cf_q[2];
    end
    // straps sampled by the clock on every edge, during reset too, never loaded by the reset itself
    if (s_strap_q[2] == s_strap_q[1]) strap_q <= s_strap_q[2];
    if (s_alarm_q[2] == s_alarm_q[1]) alarm_q <= s_alarm_q[2];
    if (s_rstn_q[2] == s_rstn_q[1])   rstn_q  <= s_rstn_q[2];
  end

  //////////////////////////////////////////////////////////////////////////////
  // avalon slave: one wait cycle, answer on the second edge of a request
  reg [2:0]  ctrl_q;
  reg [16:0] dac_code_q;
  reg        ack_q;
  reg        fault_q;
  wire       req = (avs_read_in | avs_write_in) & ~ack_q;
  always @(posedge core_clk_in)
  begin
    if (rst)
    begin
      ack_q               <= 1'b0;
      avs_waitrequest_out <= 1'b1;
      avs_readdata_out    <= 32'h0;
      ctrl_q              <= `FSKM_CTRL_RESET;
      dac_code_q          <= 17'h0;
    end
    else
    begin
      ack_q               <= req;
      avs_waitrequest_out <= ~req;
      if (req && avs_write_in && avs_byteenable_in[0])
      begin
        if (avs_address_in == `FSKM_REG_CTRL) ctrl_q <= avs_writedata_in[2:0];
      end
      if (req && avs_write_in && avs_address_in == `FSKM_REG_DAC)
      begin
        if (avs_byteenable_in[0]) dac_code_q[7:0]  <= avs_writedata_in[7:0];
        if (avs_byteenable_in[1]) dac_code_q[15:8] <= avs_writedata_in[15:8];
        if (avs_byteenable_in[2]) dac_code_q[16]   <= avs_writedata_in[16];
      end
      if (req && avs_read_in)
      begin
        case (avs_address_in)
          `FSKM_REG_CTRL:   avs_readdata_out <= {29'h0, ctrl_q};
          `FSKM_REG_STATUS: avs_readdata_out <= {26'h0, alarm_q, strap_q, fault_q,
                                                 ~rtsn_q, rx_bit_out, carrier_present_out};
          `FSKM_REG_DAC:    avs_readdata_out <= {15'h0, dac_code_q};
          default:          avs_readdata_out <= 32'h0;
        endcase
      end
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // modulator: phase accumulator, continuous across bit changes
  reg [31:0] phase_q;
  reg [17:0] slew_cnt_q;
  // increments are worked out at 64 bits; only the low word is a phase step
  localparam [63:0] MARK_INC64  = `FSKM_MARK_INC;
  localparam [63:0] SPACE_INC64 = `FSKM_SPACE_INC;
  localparam [31:0] MARK_DIV32  = `FSKM_SLEW_MARK_DIV;
  localparam [31:0] SPACE_DIV32 = `FSKM_SLEW_SPACE_DIV;
  wire [31:0] inc      = txb_q ? MARK_INC64[31:0] : SPACE_INC64[31:0];
  wire [17:0] slew_div = txb_q ? MARK_DIV32[17:0] : SPACE_DIV32[17:0];
  wire [7:0]  target = phase_q[31] ? `FSKM_OUT_LO : `FSKM_OUT_HI;
  always @(posedge core_clk_in)
  begin
    if (rst)
    begin
      phase_q     <= 32'h0;
      slew_cnt_q  <= 18'h0;
      tx_tone_out <= `FSKM_OUT_MID;
    end
    else if (rtsn_q)
    begin
      // receive mode: generator off, output parked at idle level
      phase_q     <= 32'h0;
      slew_cnt_q  <= 18'h0;
      tx_tone_out <= `FSKM_OUT_MID;
    end
    else
    begin
      phase_q <= phase_q + inc;
      // ramp one code per slew period: trapezoid edges
      if (slew_cnt_q >= slew_div - 18'h1)
      begin
        slew_cnt_q <= 18'h0;
        if (tx_tone_out < target) tx_tone_out <= tx_tone_out + 8'h1;
        else if (tx_tone_out > target) tx_tone_out <= tx_tone_out - 8'h1;
      end
      else
        slew_cnt_q <= slew_cnt_q + 18'h1;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // demodulator: half-period between comparator toggles decides the tone
  reg        rx_prev_q;
  reg [17:0] half_q;
  reg        demod_q;
  reg        cdl_prev_q;
  reg [2:0]  pulses_q;
  reg [18:0] gap_q;
  wire       rx_edge  = rx_q ^ rx_prev_q;
  wire       cd_pulse = cdl_q & ~cdl_prev_q;
  always @(posedge core_clk_in)
  begin
    if (rst)
    begin
      rx_prev_q           <= 1'b0;
      half_q              <= 18'h0;
      demod_q             <= 1'b1;
      cdl_prev_q          <= 1'b0;
      pulses_q            <= 3'h0;
      gap_q               <= 19'h0;
      carrier_present_out <= 1'b0;
      rx_bit_out          <= 1'b0;
    end
    else
    begin
      rx_prev_q  <= rx_q;
      cdl_prev_q <= cdl_q;
      if (rx_edge)
      begin
        half_q  <= 18'h0;
        demod_q <= (half_q > `FSKM_HALF_THRESH);
      end
      else if (half_q != 18'h3ffff)
        half_q <= half_q + 18'h1;
      // carrier detect: count qualified pulses, each within the gap limit
      if (rtsn_q == 1'b0)
      begin
        pulses_q            <= 3'h0;
        gap_q               <= 19'h0;
        carrier_present_out <= 1'b0;
      end
      else if (cd_pulse)
      begin
        gap_q <= 19'h0;
        if (pulses_q < `FSKM_CD_PULSES) pulses_q <= pulses_q + 3'h1;
        if (pulses_q >= `FSKM_CD_PULSES - 1) carrier_present_out <= 1'b1;
      end
      else if (gap_q >= CD_GAP_CYC - 1)
      begin
        pulses_q            <= 3'h0;
        carrier_present_out <= 1'b0;
      end
      else
        gap_q <= gap_q + 19'h1;
      rx_bit_out <= carrier_present_out ? demod_q
                                        : ctrl_q[`FSKM_CTRL_RX_IDLE];
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // watchdog: kick from internal 1.8 kHz divider or external pin
  reg [15:0] kdiv_q;
  reg        kick_prev_q;
  reg [23:0] wdt_q;
  reg [15:0] wrst_q;
  localparam [31:0] WRST_LOAD = WDT_RST_CYC;
  wire       int_kick = (kdiv_q == KICK_DIV - 1);
  wire       ext_kick = kick_q & ~kick_prev_q;
  wire       kicked   = ctrl_q[`FSKM_CTRL_KICK_EXT] ? ext_kick : int_kick;
  always @(posedge core_clk_in)
  begin
    if (rst)
    begin
      kdiv_q          <= 16'h0;
      kick_prev_q     <= 1'b0;
      wdt_q           <= 24'h0;
      wrst_q          <= 16'h0;
      fault_q         <= 1'b0;
      wdt_reset_n_out <= 1'b1;
    end
    else
    begin
      kick_prev_q <= kick_q;
      kdiv_q      <= int_kick ? 16'h0 : kdiv_q + 16'h1;
      if (kicked)
        wdt_q <= 24'h0;
      else if (wdt_q >= WDT_CYC - 1)
      begin
        wdt_q  <= 24'h0;
        wrst_q <= WRST_LOAD[15:0];
      end
      else
        wdt_q <= wdt_q + 24'h1;
      if (wrst_q != 16'h0) wrst_q <= wrst_q - 16'h1;
      wdt_reset_n_out <= (wrst_q == 16'h0);
      // fault is sticky; cleared only by reset
      if (wrst_q != 16'h0 || (cf_q && ctrl_q[`FSKM_CTRL_CLK_MON])) fault_q <= 1'b1;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // first-order sigma-delta dac; alarm level forced on a fault
  reg [17:0] sd_acc_q;
  wire [17:0] sd_sum = {1'b0, sd_acc_q[16:0]} + {1'b0, dac_code_q};
  always @(posedge core_clk_in)
  begin
    if (rst)
    begin
      sd_acc_q       <= 18'h0;
      dac_out        <= 1'b0;
      osc_enable_out <= 1'b0;
    end
    else
    begin
      sd_acc_q       <= sd_sum;
      dac_out        <= fault_q ? alarm_q : sd_sum[17];
      osc_enable_out <= ~strap_q;
    end
  end
endmodule

// >>> tb/fskm_chk.sv
// checker for the fsk modem core, bound to its ports
// assumes one clock domain and reset_in as the only reset in use
module fskm_chk #(
  parameter int CD_GAP_CYC  = 2000,
  parameter int WDT_RST_CYC = 50
) (
  input logic       core_clk_in,
  input logic       reset_in,
  input logic       avs_read_in,
  input logic       avs_write_in,
  input logic       avs_waitrequest_out,
  input logic       send_request_n_in,
  input logic [7:0] tx_tone_out,
  input logic       carrier_level_in,
  input logic       carrier_present_out,
  input logic       clk_src_strap_in,
  input logic       osc_enable_out,
  input logic       alarm_sel_in,
  input logic       wdt_reset_n_out,
  input logic       dac_out
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking cb @(posedge core_clk_in); endclocking
  default disable iff (reset_in);
  int   gap_q = 0;
  int   low_q = 0;
  logic lvl_q = 1'b0;
  // cycles since the last carrier pulse edge, and watchdog pulse length
  always @(posedge core_clk_in)
  begin
    lvl_q <= carrier_level_in;
    gap_q <= (carrier_level_in && !lvl_q) ? 0 : gap_q + 1;
    low_q <= wdt_reset_n_out ? 0 : low_q + 1;
  end
  sequence req_s; $rose(avs_read_in || avs_write_in); endsequence
  sequence ack_s; avs_waitrequest_out ##1 !avs_waitrequest_out ##1 avs_waitrequest_out; endsequence
  ////////////////////////////////////////////////////////////////////////////
  bus_ack_a: assert property (req_s |-> ack_s)
    else $error("bus answer out of time");
  tone_idle_a: assert property (send_request_n_in[*8] |-> tx_tone_out == 8'h80)
    else $error("tone not at idle level");
  tone_slew_a: assert property ((!send_request_n_in)[*8] |->
    8'(tx_tone_out - $past(tx_tone_out)) inside {8'h00, 8'h01, 8'hff})
    else $error("tone step too large");
  tone_range_a: assert property (tx_tone_out >= 8'h40 && tx_tone_out <= 8'hc0)
    else $error("tone out of swing");
  carrier_tx_a: assert property ((!send_request_n_in)[*8] |-> !carrier_present_out)
    else $error("carrier while transmitting");
  carrier_gap_a: assert property (gap_q > CD_GAP_CYC + 8 |-> !carrier_present_out)
    else $error("carrier held past gap");
  carrier_rise_a: assert property ($rose(carrier_present_out) |-> gap_q < 12)
    else $error("carrier rose without pulse");
  osc_ext_a: assert property (clk_src_strap_in[*6] |-> !osc_enable_out)
    else $error("oscillator on with external clock");
  osc_int_a: assert property ((!clk_src_strap_in)[*6] |-> osc_enable_out)
    else $error("oscillator off with internal clock");
  wdt_pulse_a: assert property ($rose(wdt_reset_n_out) |->
    low_q inside {[WDT_RST_CYC - 1:WDT_RST_CYC + 1]})
    else $error("watchdog pulse length wrong");
  dac_alarm_a: assert property ($fell(wdt_reset_n_out) |-> ##4 (dac_out == alarm_sel_in)[*8])
    else $error("dac not at alarm level");
endmodule

// >>> tb/fskm_host.sv
// host side model: uart framer on the transmit bit, carrier pulses, kicks
// assumes a shortened bit period so a character fits in a short run
module fskm_host #(
  parameter int BIT_CYC  = 2000,
  parameter int CD_CYC   = 1000,
  parameter int KICK_CYC = 500
) (
  input  logic       clk_in,
  input  logic       send_in,
  input  logic [7:0] char_in,
  input  logic       cd_on_in,
  input  logic       kick_on_in,
  output logic       tx_bit_out,
  output logic       carrier_level_out,
  output logic       kick_out
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [10:0] frame_q = 11'h7ff;
  int          bits_q = 0, cnt_q = 0, cd_q = 0, kk_q = 0;
  always @(posedge clk_in)
  begin
    if (send_in && bits_q == 0)
    begin
      frame_q <= {1'b1, ~^char_in, char_in, 1'b0};
      bits_q <= 11;
      cnt_q <= 0;
    end
    else if (bits_q != 0 && cnt_q == BIT_CYC - 1)
    begin
      frame_q <= {1'b1, frame_q[10:1]};
      bits_q <= bits_q - 1;
      cnt_q <= 0;
    end
    else if (bits_q != 0)
      cnt_q <= cnt_q + 1;
    tx_bit_out <= frame_q[0];
    cd_q <= (cd_on_in && cd_q < CD_CYC - 1) ? cd_q + 1 : 0;
    carrier_level_out <= cd_on_in && cd_q < 4;
    // kick period kept well inside the watchdog time
    kk_q <= (kick_on_in && kk_q < KICK_CYC - 1) ? kk_q + 1 : 0;
    kick_out <= kick_on_in && kk_q < 4;
  end
endmodule

// >>> tb/testbench.sv
// self-checking bench for the fsk modem core
// assumes shortened carrier gap and watchdog counts set at the instance
module testbench;
  timeunit 1ns;
  timeprecision 1ns;
  logic        clk = 1'b0, rst = 1'b1, rd = 1'b0, wr = 1'b0, srn = 1'b1, rx_tone = 1'b0;
  logic        strap = 1'b1, alarm = 1'b1, send = 1'b0, cd_on = 1'b0, kick_on = 1'b0;
  logic [3:0]  addr = 4'h0;
  logic [3:0]  be = 4'hf;
  logic [7:0]  chr = 8'h00;
  logic        cfail = 1'b0;
  logic [31:0] wdata = 32'h0, rdata = 32'h0;
  wire  [31:0] q;
  wire  [7:0]  tone;
  wire         wt, txb, cl, rxb, cd, osc, kick, wdtn, dac;
  int          fails = 0, total_checks = 0, cyc = 0;
  initial forever #5 clk = ~clk;
  fskm_modem #(.CD_GAP_CYC(2000), .WDT_CYC(3000), .WDT_RST_CYC(50), .KICK_DIV(100))
    fskm_modem_inst (.core_clk_in(clk), .reset_in(rst), .logic_reset_n_in(1'b1),
    .avs_address_in(addr), .avs_read_in(rd), .avs_write_in(wr), .avs_writedata_in(wdata),
    .avs_byteenable_in(be), .avs_readdata_out(q), .avs_waitrequest_out(wt),
    .tx_bit_in(txb), .send_request_n_in(srn), .tx_tone_out(tone), .rx_tone_in(rx_tone),
    .carrier_level_in(cl), .rx_bit_out(rxb), .carrier_present_out(cd),
    .clk_src_strap_in(strap), .osc_enable_out(osc), .alarm_sel_in(alarm), .kick_in(kick),
    .clk_fail_in(cfail), .wdt_reset_n_out(wdtn), .dac_out(dac));
  fskm_host fskm_host_inst (.clk_in(clk), .send_in(send), .char_in(chr), .cd_on_in(cd_on),
    .kick_on_in(kick_on), .tx_bit_out(txb), .carrier_level_out(cl), .kick_out(kick));
  ////////////////////////////////////////////////////////////////////////////
  task complete_run;
    $display("checks %0d mismatches %0d", total_checks, fails);
    if (fails == 0 && total_checks > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask
  task chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    total_checks++;
    if (got !== exp)
    begin
      fails++;
      $display("Error %s expected %h seen %h", what, exp, got);
    end
  endtask
  // request held from a rising edge until waitrequest is sampled low at one
  task bus(input logic w, input logic [3:0] a, input logic [31:0] d);
    @(posedge clk);
    {addr, wr, rd, wdata} <= {a, w, !w, d};
    @(posedge clk);
    while (wt !== 1'b0) @(posedge clk);
    rdata = q;
    {wr, rd} <= 2'h0;
  endtask
  task waitc(input int n);
    repeat (n) @(posedge clk);
  endtask
  // shortest gap between tone code changes; plateaus only lengthen a gap
  task step(output int m);
    int c;
    logic [7:0] p;
    m = 1000000;
    @(negedge clk);
    p = tone;
    while (tone === p) @(negedge clk);
    repeat (4)
    begin
      p = tone;
      c = 0;
      while (tone === p) @(negedge clk) c++;
      if (c < m) m = c;
    end
  endtask
  ////////////////////////////////////////////////////////////////////////////
  task regs_test;
    bus(0, 4'h0, 32'h0); chk("ctrl reset", 32'h5, rdata);
    bus(1, 4'hc, 32'hffff_ffff);
    bus(0, 4'hc, 32'h0); chk("unmapped read", 32'h0, rdata);
    bus(0, 4'h4, 32'h0); chk("status", 32'h32, rdata);
    strap <= 1'b0;
    waitc(8);
    @(negedge clk); chk("osc enable", 1'b1, osc);
    $display("test regs done");
  endtask
  task dac_test;
    int n;
    n = 0;
    bus(1, 4'h8, 32'h8000);
    bus(0, 4'h8, 32'h0); chk("dac code", 32'h8000, rdata);
    repeat (1024) @(negedge clk) n += int'(dac);
    chk("dac density", 1'b1, n >= 248 && n <= 264);
    @(posedge clk) be <= 4'h5;
    bus(1, 4'h8, 32'h0001_00ff);
    be <= 4'hf;
    bus(0, 4'h8, 32'h0); chk("dac lanes", 32'h0001_80ff, rdata);
    $display("test dac done");
  endtask
  task tx_test;
    int m;
    @(posedge clk) srn <= 1'b0;
    step(m); chk("mark slew gap", 1'b1, m >= 209 && m <= 211);
    @(posedge clk) {chr, send} <= {8'h3c, 1'b1};
    @(posedge clk) send <= 1'b0;
    waitc(8);
    step(m); chk("space slew gap", 1'b1, m >= 117 && m <= 119);
    bus(0, 4'h4, 32'h0); chk("tx mode", 1'b1, rdata[2]);
    srn <= 1'b1;
    waitc(10);
    @(negedge clk); chk("idle tone", 8'h80, tone);
    $display("test tx done");
  endtask
  task rx_test;
    @(posedge clk) cd_on <= 1'b1;
    waitc(2500);
    @(negedge clk); chk("carrier after 3", 1'b0, cd);
    waitc(600);
    @(negedge clk); chk("carrier after 4", 1'b1, cd);
    @(posedge clk) rx_tone <= 1'b1;
    waitc(22727);
    rx_tone <= 1'b0;
    waitc(10);
    @(negedge clk); chk("space bit", 1'b0, rxb);
    waitc(41655);
    rx_tone <= 1'b1;
    waitc(10);
    @(negedge clk); chk("mark bit", 1'b1, rxb);
    @(posedge clk) cd_on <= 1'b0;
    waitc(3100);
    @(negedge clk); chk("carrier drop", 1'b0, cd);
    chk("rx idle", 1'b1, rxb);
    $display("test rx done");
  endtask
  task wdt_test;
    int n;
    n = 0;
    chk("internal kick", 1'b1, wdtn);
    bus(1, 4'h0, 32'h7);
    kick_on <= 1'b1;
    waitc(6000);
    @(negedge clk); chk("external kick", 1'b1, wdtn);
    @(posedge clk) kick_on <= 1'b0;
    while (wdtn === 1'b1 && n < 4000) @(negedge clk) n++;
    chk("expiry time", 1'b1, n >= 2400 && n <= 3100);
    waitc(100);
    @(negedge clk); chk("dac alarm", 1'b1, dac);
    bus(0, 4'h4, 32'h0); chk("fault flag", 1'b1, rdata[3]);
    $display("test wdt done");
  endtask
  // mid-run reset clears the sticky fault; then a clock fail forces the low rail
  task reset_test;
    int n;
    n = 0;
    @(posedge clk) rst <= 1'b1;
    waitc(3);
    @(negedge clk); chk("reset wdt", 1'b1, wdtn);
    chk("reset tone", 8'h80, tone);
    chk("reset dac", 1'b0, dac);
    @(posedge clk) rst <= 1'b0;
    bus(0, 4'h0, 32'h0); chk("ctrl after reset", 32'h5, rdata);
    bus(0, 4'h4, 32'h0); chk("fault cleared", 1'b0, rdata[3]);
    bus(1, 4'h8, 32'h0001_ffff);
    alarm <= 1'b0;
    cfail <= 1'b1;
    waitc(12);
    repeat (64) @(negedge clk) n += int'(dac);
    chk("low rail", 32'h0, n);
    bus(0, 4'h4, 32'h0); chk("clock fail flag", 1'b1, rdata[3]);
    $display("test reset done");
  endtask
  always @(posedge clk)
  begin
    cyc++;
    if (cyc == 100000)
    begin
      fails++;
      complete_run();
    end
  end
  initial
  begin
    waitc(6);
    rst <= 1'b0;
    regs_test();
    dac_test();
    tx_test();
    rx_test();
    wdt_test();
    reset_test();
    complete_run();
  end
endmodule
bind fskm_modem fskm_chk #(.CD_GAP_CYC(CD_GAP_CYC), .WDT_RST_CYC(WDT_RST_CYC)) fskm_chk_inst (
  .core_clk_in(core_clk_in), .reset_in(reset_in), .avs_read_in(avs_read_in),
  .avs_write_in(avs_write_in), .avs_waitrequest_out(avs_waitrequest_out),
  .send_request_n_in(send_request_n_in), .tx_tone_out(tx_tone_out),
  .carrier_level_in(carrier_level_in), .carrier_present_out(carrier_present_out),
  .clk_src_strap_in(clk_src_strap_in), .osc_enable_out(osc_enable_out),
  .alarm_sel_in(alarm_sel_in), .wdt_reset_n_out(wdt_reset_n_out), .dac_out(dac_out));
